// >>> rtl/line_state_filter.sv
// line-state filter: forwards a change once it held 2**n clocks
// assumes line state synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module line_state_filter (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [3:0] log2_clocks_i,
	input wire logic [1:0] line_raw_i,
	output logic [1:0] line_filt_o,
	output logic changed_o
);
	logic [1:0] filt_q, filt_d; // forwarded state
	logic [15:0] cnt_q, cnt_d; // clocks raw has differed
	logic chg_q, chg_d; // one-cycle change pulse
	logic [16:0] limit; // 2**n, up to 32768

	// next state; a bounce back restarts the count
	always_comb
	begin
		limit = 17'h0_0001 << log2_clocks_i;
		filt_d = filt_q;
		cnt_d = 16'h0000;
		chg_d = 1'b0;
		if (line_raw_i != filt_q)
		begin
			if ({1'b0, cnt_q} + 17'h0_0001 >= limit)
			begin
				filt_d = line_raw_i;
				chg_d = 1'b1;
			end
			else
				cnt_d = cnt_q + 16'h0001;
		end
	end

	// registers; reset to J (idle full-speed)
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			filt_q <= usb_phy_ctrl_pkg::LS_J;
			cnt_q <= 16'h0000;
			chg_q <= 1'b0;
		end
		else
		begin
			filt_q <= filt_d;
			cnt_q <= cnt_d;
			chg_q <= chg_d;
		end
	end

	assign line_filt_o = filt_q;
	assign changed_o = chg_q;
endmodule : line_state_filter
`default_nettype wire

// >>> rtl/usb_phy_ctrl_pkg.sv
// package for the usb phy suspend/resume control block
// assumes a single 100 MHz core clock and an axi4-lite register bus
package usb_phy_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] PHY_CONTROL_OFFS = 8'h40;
	localparam logic [7:0] IRQ_STATUS_OFFS = 8'h44;
	localparam logic [7:0] IRQ_MASK_OFFS = 8'h48;
	localparam logic [7:0] LINE_STATUS_OFFS = 8'h4C;
	// phy control field positions
	localparam int PULLDOWN_DIS_BIT = 18;
	localparam int RESET_CAUSE_BIT = 13;
	localparam int RESUME_CAUSE_BIT = 12;
	localparam int FILTER_LSB = 8;
	localparam int FILTER_W = 4;
	localparam int AUTO_RESUME_BIT = 7;
	localparam int PHY_CFG_LSB = 4;
	localparam int PHY_CFG_W = 3;
	// writable bits of phy control, reserved bits excluded
	localparam logic [31:0] PHY_CONTROL_WMASK = 32'h0004_3FF0;
	localparam logic [31:0] PHY_CONTROL_RESET = 32'h0000_0000;
	// irq status layout: bit0 reset resume, bit1 k resume, bit2 line change
	localparam int IRQ_W = 3;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// usb line states
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;
endpackage : usb_phy_ctrl_pkg

// >>> rtl/usb_phy_suspend_resume_control.sv
// phy control register with suspend/resume detection, axi4-lite slave
// assumes phy line state and suspend flag synchronous to clk_sys_i
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - bit 18 set disables both port pulldowns
// - se0 auto-resume sets reset cause flag
// - k auto-resume sets resume cause flag
// - line changes delayed by 2^N clocks
// - auto-resume bit selects hardware resume detection
// - three config bits drive phy pins
module usb_phy_suspend_resume_control (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// phy side
	input wire logic [1:0] line_state_i,
	input wire logic suspended_i,
	output logic pulldown_8a_en_o,
	output logic pulldown_8b_en_o,
	output logic [2:0] phy_config_inputs_o,
	output logic resume_req_o,
	output logic irq_o
);
	localparam int IW = usb_phy_ctrl_pkg::IRQ_W;

	logic [31:0] ctrl_q, ctrl_d; // phy control register
	logic [IW-1:0] ists_q, ists_d; // sticky interrupt status
	logic [IW-1:0] imsk_q, imsk_d; // interrupt mask
	logic aw_held_q, aw_held_d; // write address captured
	logic w_held_q, w_held_d; // write data captured
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	// readies registered so every top output leaves a flop
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic pd_a_q, pd_a_d, pd_b_q, pd_b_d; // pulldown enables
	logic [2:0] cfg_q, cfg_d;
	logic resume_q, resume_d; // wake request to suspend controller
	logic irq_q, irq_d;
	logic [1:0] line_filt; // filtered line state
	logic line_chg; // filtered change pulse
	logic [31:0] wmask; // byte-lane mask of pending write
	logic do_wr; // write commits this cycle
	logic wake_se0, wake_k; // auto-resume events

	line_state_filter u_filter (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.log2_clocks_i(ctrl_q[usb_phy_ctrl_pkg::FILTER_LSB +: usb_phy_ctrl_pkg::FILTER_W]),
		.line_raw_i(line_state_i),
		.line_filt_o(line_filt),
		.changed_o(line_chg)
	);

	// bus write channel, register updates and status events
	always_comb
	begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		ists_d = ists_q;
		imsk_d = imsk_q;
		wmask = 32'h0000_0000;
		do_wr = 1'b0;
		// capture address and data in either order
		if (s_axi_awvalid && !aw_held_q)
		begin
			aw_held_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held_q)
		begin
			w_held_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		// a response is owed and then released
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		// hardware detects wake only when enabled
		wake_se0 = ctrl_q[usb_phy_ctrl_pkg::AUTO_RESUME_BIT] && suspended_i && line_chg
			&& line_filt == usb_phy_ctrl_pkg::LS_SE0;
		wake_k = ctrl_q[usb_phy_ctrl_pkg::AUTO_RESUME_BIT] && suspended_i && line_chg
			&& line_filt == usb_phy_ctrl_pkg::LS_K;
		for (int b = 0; b < 4; b++)
			wmask[b*8 +: 8] = {8{wstrb_q[b]}};
		if (aw_held_q && w_held_q && !bvalid_q)
		begin
			do_wr = 1'b1;
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = usb_phy_ctrl_pkg::RESP_OKAY;
			if (awaddr_q[7:2] == usb_phy_ctrl_pkg::PHY_CONTROL_OFFS[7:2])
				ctrl_d = (ctrl_q & ~(wmask & usb_phy_ctrl_pkg::PHY_CONTROL_WMASK))
					| (wdata_q & wmask & usb_phy_ctrl_pkg::PHY_CONTROL_WMASK);
			else if (awaddr_q[7:2] == usb_phy_ctrl_pkg::IRQ_STATUS_OFFS[7:2])
			begin
				// write one to clear
				if (wstrb_q[0])
					ists_d = ists_q & ~wdata_q[IW-1:0];
			end
			else if (awaddr_q[7:2] == usb_phy_ctrl_pkg::IRQ_MASK_OFFS[7:2])
			begin
				if (wstrb_q[0])
					imsk_d = wdata_q[IW-1:0];
			end
			else if (awaddr_q[7:2] != usb_phy_ctrl_pkg::LINE_STATUS_OFFS[7:2])
				bresp_d = usb_phy_ctrl_pkg::RESP_SLVERR;
		end
		// se0 wake sets reset cause, beats clear
		if (wake_se0)
			ctrl_d[usb_phy_ctrl_pkg::RESET_CAUSE_BIT] = 1'b1;
		// k wake sets resume cause, beats clear
		if (wake_k)
			ctrl_d[usb_phy_ctrl_pkg::RESUME_CAUSE_BIT] = 1'b1;
		// sticky events win over a same-cycle clear
		ists_d = ists_d | {line_chg, wake_k, wake_se0};
		irq_d = |(ists_d & imsk_d);
		pd_a_d = !ctrl_d[usb_phy_ctrl_pkg::PULLDOWN_DIS_BIT];
		pd_b_d = !ctrl_d[usb_phy_ctrl_pkg::PULLDOWN_DIS_BIT];
		cfg_d = ctrl_d[usb_phy_ctrl_pkg::PHY_CFG_LSB +: usb_phy_ctrl_pkg::PHY_CFG_W];
		// wake request held for one cycle per event
		resume_d = wake_se0 || wake_k;
		// slot free next cycle means ready next cycle
		awready_d = !aw_held_d;
		wready_d = !w_held_d;
	end

	// bus read channel; reads have no side effects
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = usb_phy_ctrl_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			if (s_axi_araddr[7:2] == usb_phy_ctrl_pkg::PHY_CONTROL_OFFS[7:2])
				rdata_d = ctrl_q & usb_phy_ctrl_pkg::PHY_CONTROL_WMASK;
			else if (s_axi_araddr[7:2] == usb_phy_ctrl_pkg::IRQ_STATUS_OFFS[7:2])
				rdata_d[IW-1:0] = ists_q;
			else if (s_axi_araddr[7:2] == usb_phy_ctrl_pkg::IRQ_MASK_OFFS[7:2])
				rdata_d[IW-1:0] = imsk_q;
			else if (s_axi_araddr[7:2] == usb_phy_ctrl_pkg::LINE_STATUS_OFFS[7:2])
				rdata_d[2:0] = {suspended_i, line_filt};
			else
				rresp_d = usb_phy_ctrl_pkg::RESP_SLVERR;
		end
		// one read in flight: address refused while data is owed
		arready_d = !rvalid_d;
	end

	// all state registers
	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			ctrl_q <= usb_phy_ctrl_pkg::PHY_CONTROL_RESET;
			ists_q <= '0;
			imsk_q <= usb_phy_ctrl_pkg::IRQ_MASK_RESET;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
			pd_a_q <= 1'b1;
			pd_b_q <= 1'b1;
			cfg_q <= 3'h0;
			resume_q <= 1'b0;
			irq_q <= 1'b0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			ists_q <= ists_d;
			imsk_q <= imsk_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			pd_a_q <= pd_a_d;
			pd_b_q <= pd_b_d;
			cfg_q <= cfg_d;
			resume_q <= resume_d;
			irq_q <= irq_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
		end
	end

	// ready is high while the capture slot is free
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_arready = arready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign pulldown_8a_en_o = pd_a_q;
	assign pulldown_8b_en_o = pd_b_q;
	assign phy_config_inputs_o = cfg_q;
	assign resume_req_o = resume_q;
	assign irq_o = irq_q;
endmodule : usb_phy_suspend_resume_control
`default_nettype wire

// >>> verif/phy_ctrl_sva.sv
// port checker for the phy control block
// assumes it is bound onto the block top
`timescale 1ns/1ps
`default_nettype none
module phy_ctrl_sva (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] line_state_i,
	input wire logic suspended_i,
	input wire logic pulldown_8a_en_o,
	input wire logic pulldown_8b_en_o,
	input wire logic [2:0] phy_config_inputs_o,
	input wire logic resume_req_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	// address of the read in flight, so read data can be judged
	logic [7:0] rd_addr_q;
	logic [7:0] rd_addr_d;
	always_comb
	begin
		rd_addr_d = rd_addr_q;
		if (!rstn_i)
			rd_addr_d = 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr_d = s_axi_araddr;
	end
	always_ff @(posedge clk_sys_i)
		rd_addr_q <= rd_addr_d;
	chk_pd_pair: assert property (
		pulldown_8a_en_o == pulldown_8b_en_o) else $error("pulldown enables differ");
	chk_pd_write: assert property (
		!$stable(pulldown_8a_en_o) |-> $rose(s_axi_bvalid)) else $error("pulldown moved alone");
	chk_cfg_write: assert property (
		!$stable(phy_config_inputs_o) |-> $rose(s_axi_bvalid)) else $error("config moved alone");
	chk_wake_pulse: assert property (
		resume_req_o |=> !resume_req_o) else $error("resume request too long");
	chk_wake_susp: assert property (
		resume_req_o |-> $past(suspended_i, 1)) else $error("resume without suspend");
	chk_wake_line: assert property (
		resume_req_o |-> $past(line_state_i, 2) != 2'h1) else $error("resume from idle line");
	chk_resv_zero: assert property (
		s_axi_rvalid && rd_addr_q == 8'h40 |-> (s_axi_rdata & 32'hFFFB_C00F) == 32'h0000_0000)
		else $error("reserved bits set");
endmodule : phy_ctrl_sva
`default_nettype wire

// >>> verif/test_usb_phy_suspend_resume_control.sv
// bench for the phy control block over axi4-lite
// assumes the line model and the port checker beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("mismatch %0t %h %h", $time, a, b); end end
bind usb_phy_suspend_resume_control phy_ctrl_sva u_phy_ctrl_sva (.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_bvalid(s_axi_bvalid), .line_state_i(line_state_i), .suspended_i(suspended_i),
	.pulldown_8a_en_o(pulldown_8a_en_o), .pulldown_8b_en_o(pulldown_8b_en_o),
	.phy_config_inputs_o(phy_config_inputs_o), .resume_req_o(resume_req_o));
module test_usb_phy_suspend_resume_control;
	logic clk_sys_i, rstn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, suspended_i, pd_a, pd_b, resume_req_o, irq_o;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, line_state_i, rd_resp;
	logic [3:0] s_axi_wstrb;
	logic [2:0] cfg;
	int checks, fails, cyc, t0, pulses, last_pulse, l0, n;
	usb_phy_suspend_resume_control u_usb_phy_suspend_resume_control (.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .line_state_i(line_state_i), .suspended_i(suspended_i),
		.pulldown_8a_en_o(pd_a), .pulldown_8b_en_o(pd_b), .phy_config_inputs_o(cfg),
		.resume_req_o(resume_req_o), .irq_o(irq_o));
	usb_line_model u_usb_line_model (.clk_sys_i(clk_sys_i), .line_state_o(line_state_i),
		.suspended_o(suspended_i));
	always #5 clk_sys_i = ~clk_sys_i;
	// cycle count, pulse log and hang guard; nba keeps reads race free
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (resume_req_o === 1'b1)
		begin
			pulses <= pulses + 1;
			last_pulse <= cyc;
		end
		if (cyc == 4000)
		begin
			fails++;
			$display("mismatch %0t timeout", $time);
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	// write with both channels offered together, each dropped once taken
	// waits without limit: only the hang guard ends a stuck wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, e)
	endtask : wr
	// read one word and compare it
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk_sys_i);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		`CHK(rd_data, e)
	endtask : rdchk
	// irq settles a couple of cycles after the write
	task automatic irqchk(input logic e);
		repeat (2) @(posedge clk_sys_i);
		`CHK(irq_o, e)
	endtask : irqchk
	// suspended link sees st long enough to pass any filter length used
	task automatic wake(input logic [1:0] st);
		u_usb_line_model.set_line(st, 1'b1);
		t0 = cyc;
		repeat (20) @(posedge clk_sys_i);
		u_usb_line_model.set_line(2'h1, 1'b0);
		repeat (20) @(posedge clk_sys_i);
	endtask : wake
	initial
	begin
		{clk_sys_i, rstn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
		{s_axi_wdata, checks, fails, cyc, pulses, last_pulse} = 0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rdchk(8'h40, 32'h0000_0000);
		`CHK({pd_a, pd_b, cfg}, 5'h18)
		wr(8'h40, 32'hFFFF_FFFF, 2'h0);
		rdchk(8'h40, 32'h0004_3FF0);
		`CHK(rd_resp, 2'h0)
		`CHK({pd_a, pd_b, cfg}, 5'h07)
		wr(8'h50, 32'h0000_0001, 2'h2);
		rdchk(8'h50, 32'h0000_0000);
		`CHK(rd_resp, 2'h2)
		wr(8'h48, 32'h0000_0002, 2'h0);
		wr(8'h40, 32'h0000_0080, 2'h0);
		wake(2'h2);
		l0 = last_pulse - t0;
		rdchk(8'h40, 32'h0000_1080);
		irqchk(1'b1);
		wr(8'h48, 32'h0000_0000, 2'h0);
		irqchk(1'b0);
		wr(8'h48, 32'h0000_0002, 2'h0);
		irqchk(1'b1);
		wr(8'h44, 32'h0000_0007, 2'h0);
		irqchk(1'b0);
		wr(8'h40, 32'h0000_0380, 2'h0);
		wake(2'h0);
		`CHK(last_pulse - t0 - l0, 7)
		rdchk(8'h40, 32'h0000_2380);
		// se0 wake plus two filtered line changes
		rdchk(8'h44, 32'h0000_0005);
		// only the low byte lane may move
		s_axi_wstrb <= 4'h1;
		wr(8'h40, 32'hFFFF_FFFF, 2'h0);
		s_axi_wstrb <= 4'hF;
		rdchk(8'h40, 32'h0000_23F0);
		`CHK({pd_a, pd_b, cfg}, 5'h1F)
		wr(8'h40, 32'h0000_0000, 2'h0);
		n = pulses;
		u_usb_line_model.set_line(2'h2, 1'b1);
		repeat (8) @(posedge clk_sys_i);
		rdchk(8'h4C, 32'h0000_0006);
		u_usb_line_model.set_line(2'h1, 1'b0);
		`CHK(pulses, n)
		final_report();
	end
endmodule : test_usb_phy_suspend_resume_control
`default_nettype wire

// >>> verif/usb_line_model.sv
// line state and suspend flag of the usb link
// assumes the bench calls set_line between edges
`timescale 1ns/1ps
`default_nettype none
module usb_line_model (
	input wire logic clk_sys_i,
	output logic [1:0] line_state_o,
	output logic suspended_o
);
	// idle link: pulled-up j, not suspended
	initial
	begin
		line_state_o = 2'h1;
		suspended_o = 1'b0;
	end
	task automatic set_line(input logic [1:0] st, input logic susp);
		@(posedge clk_sys_i);
		line_state_o <= st;
		suspended_o <= susp;
	endtask : set_line
endmodule : usb_line_model
`default_nettype wire
